// *** hw/ssq_pkg.sv ***
// Shared constants and types for the servo start-up sequencer ends
package ssq_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int CYC_PER_MS = CLK_MHZ * 1000;
	localparam int INIT_TIME_MS = 4500;
	localparam int INIT_CYCLES = INIT_TIME_MS * CYC_PER_MS;
	localparam int RECOG_TIME_MS = 2;
	localparam int RECOG_CYCLES = RECOG_TIME_MS * CYC_PER_MS;
	localparam int HOLD_TIME_MS = 1;
	localparam int HOLD_CYCLES = HOLD_TIME_MS * CYC_PER_MS;
	localparam int MODE_TIME_MS = 2;
	localparam int MODE_CYCLES = MODE_TIME_MS * CYC_PER_MS;
	localparam int OL_TIME_MS = 100;
	localparam int OL_CYCLES = OL_TIME_MS * CYC_PER_MS;
	localparam int CNT_W = 32;

	// ------------------------------------------------------------
	// Control modes and load thresholds
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_POSITION = 2'h0;
	localparam logic [1:0] MODE_SPEED = 2'h1;
	localparam logic [1:0] MODE_TORQUE = 2'h2;
	localparam logic [7:0] LOAD_FIRST_LIMIT = 8'h78;
	localparam logic [7:0] LOAD_SECOND_LIMIT = 8'hC8;

	// ------------------------------------------------------------
	// Host register map over APB
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam int CTRL_SERVO_ON = 0;
	localparam int CTRL_ALM_RST = 1;
	localparam int CTRL_MODE_LO = 2;
	localparam int CTRL_MODE_HI = 3;
	localparam int CTRL_MAIN_PWR = 4;

	typedef enum logic [2:0] {
		ST_INIT = 3'b000,
		ST_SRDY = 3'b001,
		ST_RUN = 3'b011,
		ST_ALARM = 3'b010
	} ssq_state_type;

	typedef enum logic [2:0] {
		HS_WAIT = 3'b000,
		HS_IDLE = 3'b001,
		HS_PULSE = 3'b011,
		HS_GAP = 3'b010
	} ssq_hstate_type;

endpackage

// *** hw/ssq_link_if.sv ***
// Discrete sequence wires between host controller and amplifier
interface ssq_link_if;
	logic ctrl_ready;
	logic op_ready;
	logic overload_alarm_first;
	logic overload_alarm_second;
	logic servo_on;
	logic alarm_reset;
	logic main_power;
	logic [1:0] mode_sel;
	logic [1:0] mode_active;

	modport dev (
		output ctrl_ready, op_ready, overload_alarm_first,
		output overload_alarm_second, mode_active,
		input servo_on, alarm_reset, main_power, mode_sel
	);
	modport host (
		input ctrl_ready, op_ready, overload_alarm_first,
		input overload_alarm_second, mode_active,
		output servo_on, alarm_reset, main_power, mode_sel
	);
endinterface

// *** hw/ssq_host.sv ***
// Host controller end: APB registers driving the sequence inputs
module ssq_host #(
	parameter int HOLD_CYC = ssq_pkg::HOLD_CYCLES,
	parameter int MODE_CYC = ssq_pkg::MODE_CYCLES
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	ssq_link_if.host link
);

	localparam int CNT_W = ssq_pkg::CNT_W;

	// ------------------------------------------------------------
	// APB slave: no wait states while clk_en is high, unmapped reads zero with error
	// ------------------------------------------------------------
	logic [4:0] ctrl_reg;
	logic [31:0] prdata_reg;
	logic err_reg;
	logic servo_req_reg;
	logic rst_req_reg;
	logic [1:0] mode_req_reg;
	logic mode_req_new;
	logic [ssq_pkg::CNT_W-1:0] cnt_reg;
	ssq_pkg::ssq_hstate_type st_reg;
	logic acc;
	assign acc = psel && penable && clk_en;
	assign pready = clk_en;
	assign prdata = prdata_reg;
	assign pslverr = err_reg;

	// Control register write; servo and reset bits queue requests
	always_ff @(posedge clock) begin
		if (srst) begin
			ctrl_reg <= 5'h00;
		end else if (acc && pwrite && paddr == ssq_pkg::REG_CTRL) begin
			ctrl_reg <= pwdata[4:0];
		end
	end

	// Read data and error, registered at the setup-phase edge
	always_ff @(posedge clock) begin
		if (srst) begin
			prdata_reg <= 32'h0000_0000;
			err_reg <= 1'b0;
		end else if (psel && !penable && clk_en) begin
			err_reg <= !(paddr == ssq_pkg::REG_CTRL ||
				paddr == ssq_pkg::REG_STATUS);
			if (paddr == ssq_pkg::REG_CTRL) begin
				prdata_reg <= {27'h0, ctrl_reg};
			end else if (paddr == ssq_pkg::REG_STATUS) begin
				prdata_reg <= {25'h0, st_reg == ssq_pkg::HS_GAP,
					link.mode_active, link.overload_alarm_second,
					link.overload_alarm_first, link.op_ready,
					link.ctrl_ready};
			end else begin
				prdata_reg <= 32'h0000_0000;
			end
		end
	end

	// ------------------------------------------------------------
	// Sequence drive
	// ------------------------------------------------------------
	assign mode_req_new = ctrl_reg[ssq_pkg::CTRL_MODE_HI:
		ssq_pkg::CTRL_MODE_LO] != mode_req_reg;

	// Commands wait for control-ready, pulses hold 1 ms, mode gap 2 ms
	always_ff @(posedge clock) begin
		if (srst) begin
			st_reg <= ssq_pkg::HS_WAIT;
			cnt_reg <= '0;
			servo_req_reg <= 1'b0;
			rst_req_reg <= 1'b0;
			mode_req_reg <= ssq_pkg::MODE_POSITION;
		end else if (clk_en) begin
			case (st_reg)
				ssq_pkg::HS_WAIT: begin
					if (link.ctrl_ready) begin
						st_reg <= ssq_pkg::HS_IDLE;
					end
				end
				ssq_pkg::HS_IDLE: begin
					if (!link.ctrl_ready && !rst_req_reg) begin
						st_reg <= ssq_pkg::HS_WAIT;
					end else if (mode_req_new) begin
						mode_req_reg <= ctrl_reg[3:2];
						cnt_reg <= '0;
						st_reg <= ssq_pkg::HS_GAP;
					end else if (ctrl_reg[ssq_pkg::CTRL_ALM_RST] !=
						rst_req_reg) begin
						rst_req_reg <= ctrl_reg[ssq_pkg::CTRL_ALM_RST];
						cnt_reg <= '0;
						st_reg <= ssq_pkg::HS_PULSE;
					end else begin
						servo_req_reg <= ctrl_reg[ssq_pkg::CTRL_SERVO_ON];
					end
				end
				ssq_pkg::HS_PULSE: begin
					cnt_reg <= cnt_reg + 1'b1;
					// Toggle value is kept, so one write gives one pulse
					if (cnt_reg == CNT_W'(HOLD_CYC - 1)) begin
						st_reg <= ssq_pkg::HS_IDLE;
					end
				end
				default: begin
					cnt_reg <= cnt_reg + 1'b1;
					if (cnt_reg == CNT_W'(MODE_CYC - 1)) begin
						st_reg <= ssq_pkg::HS_IDLE;
					end
				end
			endcase
		end
	end

	// Pin outputs registered; main power follows control bit, switching on only with control-ready
	always_ff @(posedge clock) begin
		if (srst) begin
			link.servo_on <= 1'b0;
			link.alarm_reset <= 1'b0;
			link.mode_sel <= ssq_pkg::MODE_POSITION;
			link.main_power <= 1'b0;
		end else if (clk_en) begin
			link.servo_on <= servo_req_reg && link.ctrl_ready;
			link.alarm_reset <= st_reg == ssq_pkg::HS_PULSE;
			link.mode_sel <= mode_req_reg;
			link.main_power <= ctrl_reg[ssq_pkg::CTRL_MAIN_PWR] &&
				(link.ctrl_ready || link.main_power);
		end
	end

endmodule

// *** hw/ssq_device.sv ***
// Amplifier end: start-up sequencer, mode switch and overload alarms
// ------------------------------------------------------------
// Summary of operation
// - Initialization lasts about 4.5 s after power
// - Option module lengthens init; host watches ready
// - Control-ready high only after initialization done
// - Host requests servo-on after seeing control-ready
// - Servo-on accepted raises operation-ready; commands after
// - Control power first: time init from it
// - Host applies main power after control-ready
// - Sequence inputs recognised within 2 ms
// - Host holds sequence inputs at least 1 ms
// - Control mode switch completes within 2 ms
// - Host waits 2 ms after mode change
// - Overload alarm after load persists detection time
// ------------------------------------------------------------
module ssq_device #(
	parameter int INIT_CYC = ssq_pkg::INIT_CYCLES,
	parameter int RECOG_CYC = ssq_pkg::RECOG_CYCLES,
	parameter int OL_CYC = ssq_pkg::OL_CYCLES
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic option_fitted,
	input wire logic option_done,
	input wire logic [7:0] load_factor,
	input wire logic [7:0] speed_factor,
	output logic cmd_enable,
	ssq_link_if.dev link
);

	localparam int CNT_W = ssq_pkg::CNT_W;

	// ------------------------------------------------------------
	// Input recognition: one sample per quarter window, well inside 2 ms
	// ------------------------------------------------------------
	logic [CNT_W-1:0] smp_cnt_reg;
	logic smp_tick;
	logic servo_on_reg;
	logic alarm_reset_reg;
	logic alarm_reset_prev_reg;
	logic [1:0] mode_sel_reg;
	assign smp_tick = smp_cnt_reg == '0;

	// Quarter-window sampling: a 1 ms pulse is always seen inside 2 ms
	always_ff @(posedge clock) begin
		if (srst) begin
			smp_cnt_reg <= '0;
		end else if (clk_en) begin
			if (smp_cnt_reg == CNT_W'(RECOG_CYC / 4 - 1)) begin
				smp_cnt_reg <= '0;
			end else begin
				smp_cnt_reg <= smp_cnt_reg + 1'b1;
			end
		end
	end

	// Captured copies of the sequence inputs
	always_ff @(posedge clock) begin
		if (srst) begin
			servo_on_reg <= 1'b0;
			alarm_reset_reg <= 1'b0;
			alarm_reset_prev_reg <= 1'b0;
			mode_sel_reg <= ssq_pkg::MODE_POSITION;
		end else if (clk_en && smp_tick) begin
			servo_on_reg <= link.servo_on;
			alarm_reset_reg <= link.alarm_reset;
			alarm_reset_prev_reg <= alarm_reset_reg;
			mode_sel_reg <= link.mode_sel;
		end
	end

	// ------------------------------------------------------------
	// Start-up state machine; srst stands for control power on
	// ------------------------------------------------------------
	ssq_pkg::ssq_state_type st_reg;
	logic [CNT_W-1:0] init_cnt_reg;
	logic init_done;
	logic alarm_any;
	logic alarm_clear;
	assign init_done = init_cnt_reg == CNT_W'(INIT_CYC - 1);
	assign alarm_clear = alarm_reset_reg && !alarm_reset_prev_reg &&
		clk_en && smp_tick;

	// Init timer runs from reset whatever main power does
	always_ff @(posedge clock) begin
		if (srst) begin
			init_cnt_reg <= '0;
		end else if (clk_en && !init_done) begin
			init_cnt_reg <= init_cnt_reg + 1'b1;
		end
	end

	// Sequence: init, control-ready, run; alarm drops operation
	always_ff @(posedge clock) begin
		if (srst) begin
			st_reg <= ssq_pkg::ST_INIT;
		end else if (clk_en) begin
			case (st_reg)
				ssq_pkg::ST_INIT: begin
					// Option module holds us until it reports done
					if (init_done && (!option_fitted || option_done)) begin
						st_reg <= ssq_pkg::ST_SRDY;
					end
				end
				ssq_pkg::ST_SRDY: begin
					if (alarm_any) begin
						st_reg <= ssq_pkg::ST_ALARM;
					end else if (servo_on_reg && link.main_power) begin
						st_reg <= ssq_pkg::ST_RUN;
					end
				end
				ssq_pkg::ST_RUN: begin
					if (alarm_any) begin
						st_reg <= ssq_pkg::ST_ALARM;
					end else if (!servo_on_reg || !link.main_power) begin
						st_reg <= ssq_pkg::ST_SRDY;
					end
				end
				default: begin
					if (alarm_clear) begin
						st_reg <= ssq_pkg::ST_SRDY;
					end
				end
			endcase
		end
	end

	// Ready outputs registered from state
	always_ff @(posedge clock) begin
		if (srst) begin
			link.ctrl_ready <= 1'b0;
			link.op_ready <= 1'b0;
		end else if (clk_en) begin
			link.ctrl_ready <= st_reg != ssq_pkg::ST_INIT;
			link.op_ready <= st_reg == ssq_pkg::ST_RUN;
		end
	end

	// ------------------------------------------------------------
	// Control mode switch: new mode takes effect after 0.5 ms settle
	// ------------------------------------------------------------
	logic [CNT_W-1:0] mode_cnt_reg;
	logic mode_busy;
	assign mode_busy = link.mode_active != mode_sel_reg;
	assign cmd_enable = link.op_ready && !mode_busy;

	// Settling counter keeps running if the selection moves again; it clears when not busy and when the new mode is taken
	always_ff @(posedge clock) begin
		if (srst) begin
			mode_cnt_reg <= '0;
			link.mode_active <= ssq_pkg::MODE_POSITION;
		end else if (clk_en) begin
			if (!mode_busy) begin
				mode_cnt_reg <= '0;
			end else if (mode_cnt_reg == CNT_W'(RECOG_CYC / 4 - 1)) begin
				link.mode_active <= mode_sel_reg;
				mode_cnt_reg <= '0;
			end else begin
				mode_cnt_reg <= mode_cnt_reg + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Overload detection: accumulate excess, faster at high speed
	// ------------------------------------------------------------
	logic [CNT_W-1:0] ol_acc_reg;
	logic [CNT_W-1:0] ol_step;
	logic ol_trip;
	// Speed at half scale or more doubles the heating rate unless load is over the second limit, a coarse curve
	assign ol_step = (load_factor > ssq_pkg::LOAD_SECOND_LIMIT) ?
		CNT_W'(4) : (speed_factor[7] ? CNT_W'(2) : CNT_W'(1));
	assign ol_trip = ol_acc_reg >= CNT_W'(OL_CYC);
	assign alarm_any = link.overload_alarm_first ||
		link.overload_alarm_second;

	// Accumulator bleeds off when load is back in range
	always_ff @(posedge clock) begin
		if (srst) begin
			ol_acc_reg <= '0;
		end else if (clk_en) begin
			if (load_factor > ssq_pkg::LOAD_FIRST_LIMIT) begin
				if (!ol_trip) begin
					ol_acc_reg <= ol_acc_reg + ol_step;
				end
			end else if (ol_acc_reg != '0) begin
				ol_acc_reg <= ol_acc_reg - 1'b1;
			end
		end
	end

	// Latched alarms; a trip in the reset cycle wins over the clear
	always_ff @(posedge clock) begin
		if (srst) begin
			link.overload_alarm_first <= 1'b0;
			link.overload_alarm_second <= 1'b0;
		end else if (clk_en) begin
			if (ol_trip && st_reg != ssq_pkg::ST_INIT) begin
				if (load_factor > ssq_pkg::LOAD_SECOND_LIMIT) begin
					link.overload_alarm_second <= 1'b1;
				end else begin
					link.overload_alarm_first <= 1'b1;
				end
			end else if (alarm_clear) begin
				link.overload_alarm_first <= 1'b0;
				link.overload_alarm_second <= 1'b0;
			end
		end
	end

endmodule

// *** verification/ssq_link_properties.sv ***
// Concurrent checks on the sequence wires between host and amplifier
module ssq_link_properties #(
	parameter int INIT_CYC = 50
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic ctrl_ready,
	input wire logic op_ready,
	input wire logic overload_alarm_first,
	input wire logic overload_alarm_second,
	input wire logic servo_on,
	input wire logic alarm_reset,
	input wire logic main_power,
	input wire logic [1:0] mode_sel,
	input wire logic [1:0] mode_active
);
	logic [15:0] up_reg;
	logic [15:0] arst_reg;
	logic alarm;

	// ------
	// Helper counters
	// ------
	// Saturate so a long run never wraps into a false pass
	always_ff @(posedge clock) begin
		if (srst)
			up_reg <= '0;
		else if (up_reg != 16'hFFFF)
			up_reg <= up_reg + 16'h0001;
	end

	// Cycles since the alarm-reset wire was last high
	always_ff @(posedge clock) begin
		if (srst)
			arst_reg <= 16'hFFFF;
		else if (alarm_reset)
			arst_reg <= '0;
		else if (arst_reg != 16'hFFFF)
			arst_reg <= arst_reg + 16'h0001;
	end

	assign alarm = overload_alarm_first | overload_alarm_second;

	// ------
	// Properties
	// ------
	default clocking @(posedge clock); endclocking
	default disable iff (srst);

	chk_ready_after_init: assert property (
		ctrl_ready |-> up_reg >= INIT_CYC)
		else $error("control ready before init time");
	chk_op_needs_ready: assert property (
		op_ready |-> ctrl_ready)
		else $error("operation ready without control ready");
	chk_op_on_request: assert property (
		$rose(servo_on) && ctrl_ready && main_power |-> ##[1:16] op_ready)
		else $error("servo-on request not recognised in time");
	chk_op_drops_off: assert property (
		!servo_on [*8] |=> !op_ready)
		else $error("operation ready without servo-on");
	chk_mode_follow: assert property (
		$changed(mode_sel) |-> ##[1:16] mode_active == mode_sel)
		else $error("mode switch too slow");
	chk_mode_target: assert property (
		$changed(mode_active) |-> mode_active == mode_sel)
		else $error("active mode moved away from selection");
	chk_alarm_latched: assert property (
		$fell(alarm) |-> arst_reg <= 16'h0010)
		else $error("alarm cleared without reset pulse");
	chk_alarm_blocks_op: assert property (
		alarm [*3] |-> !op_ready)
		else $error("operation ready during alarm");
	chk_alarm_after_init: assert property (
		alarm |-> up_reg >= INIT_CYC)
		else $error("alarm raised during init");

	cov_run: cover property ($rose(op_ready));
	cov_second: cover property ($rose(overload_alarm_second));
	cov_mode: cover property ($changed(mode_active));
endmodule

// *** verification/testbench.sv ***
// Self-checking bench: host end and amplifier end joined by the link
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int INIT_CYC = 50;
	localparam int MODE_CYC = 16;
	localparam int OL_CYC = 20;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic clk_en = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic option_fitted = 1'b0;
	logic option_done = 1'b0;
	logic [7:0] load_factor = 8'h00;
	logic [7:0] speed_factor = 8'h00;
	logic cmd_enable;
	logic [31:0] lvec;
	logic [31:0] rd;
	logic err;
	logic [1:0] modes [3] = '{ssq_pkg::MODE_SPEED, ssq_pkg::MODE_TORQUE,
		ssq_pkg::MODE_POSITION};
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n;

	ssq_link_if link ();

	// Short counts keep the run brief; expectations derive from them
	ssq_host #(.HOLD_CYC(8), .MODE_CYC(MODE_CYC)) i_ssq_host (
		.clock(clock), .srst(srst), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link));
	ssq_device #(.INIT_CYC(INIT_CYC), .RECOG_CYC(16), .OL_CYC(OL_CYC))
		i_ssq_device (
		.clock(clock), .srst(srst), .clk_en(clk_en),
		.option_fitted(option_fitted), .option_done(option_done),
		.load_factor(load_factor), .speed_factor(speed_factor),
		.cmd_enable(cmd_enable), .link(link));
	ssq_link_properties #(.INIT_CYC(INIT_CYC)) i_ssq_link_properties (
		.clock(clock), .srst(srst), .ctrl_ready(link.ctrl_ready),
		.op_ready(link.op_ready),
		.overload_alarm_first(link.overload_alarm_first),
		.overload_alarm_second(link.overload_alarm_second),
		.servo_on(link.servo_on), .alarm_reset(link.alarm_reset),
		.main_power(link.main_power), .mode_sel(link.mode_sel),
		.mode_active(link.mode_active));

	// Link state laid out like the status word, bits 5:0
	assign lvec = {26'h000_0000, link.mode_active,
		link.overload_alarm_second, link.overload_alarm_first,
		link.op_ready, link.ctrl_ready};

	// Clock and cycles since reset release
	initial begin
		forever #2 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc <= srst ? 0 : cyc + 1;
	end

	// ------
	// Compare, bus and wait tasks
	// ------
	task automatic cmp_word(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cmp_flag(input string what, input logic exp,
		input logic got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask

	// Request held until pready is sampled high; idle edge afterwards
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	task automatic wr_ctrl(input logic [31:0] d);
		apb(1'b1, ssq_pkg::REG_CTRL, d);
	endtask

	task automatic rd_chk(input logic [31:0] m, input logic [31:0] exp);
		apb(1'b0, ssq_pkg::REG_STATUS, 32'h0000_0000);
		cmp_word("status word", exp, rd & m);
	endtask

	// Bounded wait on the link; a miss shows up as a mismatch
	task automatic wait_link(input logic [31:0] m, input logic [31:0] exp,
		input int lim);
		n = 0;
		while ((lvec & m) !== exp && n < lim) begin
			@(posedge clock);
			n++;
		end
		cmp_word("link state", exp, lvec & m);
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ------
	// Tests
	// ------
	initial begin
		repeat (5000) @(posedge clock);
		error_cnt++;
		give_verdict();
	end

	initial begin
		repeat (20) @(posedge clock);
		srst <= 1'b0;
		rd_chk(32'h0000_007F, 32'h0000_0000);
		apb(1'b0, 8'h08, 32'h0000_0000);
		cmp_flag("unmapped error", 1'b1, err);
		cmp_word("unmapped data", 32'h0000_0000, rd);
		wait_link(32'h0000_0001, 32'h0000_0001, 200);
		cmp_flag("init length", 1'b1, cyc >= INIT_CYC && cyc <= INIT_CYC + 6);
		wr_ctrl(32'h0000_0011);
		wait_link(32'h0000_0003, 32'h0000_0003, 40);
		cmp_flag("command enable", 1'b1, cmd_enable);
		foreach (modes[i]) begin
			wr_ctrl(32'h0000_0011 | (32'(modes[i]) << 2));
			rd_chk(32'h0000_0040, 32'h0000_0040);
			repeat (MODE_CYC + 4) @(posedge clock);
			rd_chk(32'h0000_007F, 32'h0000_0003 | (32'(modes[i]) << 4));
			cmp_flag("command enable", 1'b1, cmd_enable);
		end
		// Moderate load: first variant after the full detection time
		// Clock enable low first: nothing may accumulate while frozen
		clk_en <= 1'b0;
		load_factor <= 8'h80;
		repeat (30) @(posedge clock);
		cmp_word("link frozen", 32'h0000_0003, lvec & 32'h0000_000F);
		cmp_flag("bus frozen", 1'b0, pready);
		clk_en <= 1'b1;
		wait_link(32'h0000_000E, 32'h0000_0004, 100);
		cmp_flag("first trip time", 1'b1, n >= OL_CYC);
		load_factor <= 8'h00;
		repeat (30) @(posedge clock);
		rd_chk(32'h0000_000E, 32'h0000_0004);
		wr_ctrl(32'h0000_0013);
		wait_link(32'h0000_000F, 32'h0000_0003, 60);
		// Heavy load at high speed trips sooner, second variant
		load_factor <= 8'hD0;
		speed_factor <= 8'h80;
		wait_link(32'h0000_000E, 32'h0000_0008, 100);
		cmp_flag("second trip time", 1'b1, n < OL_CYC);
		load_factor <= 8'h00;
		speed_factor <= 8'h00;
		wr_ctrl(32'h0000_0011);
		wait_link(32'h0000_000F, 32'h0000_0003, 60);
		wr_ctrl(32'h0000_0010);
		wait_link(32'h0000_0003, 32'h0000_0001, 40);
		// Second reset in mid-run, now with an option module fitted
		srst <= 1'b1;
		option_fitted <= 1'b1;
		repeat (2) @(posedge clock);
		cmp_word("link in reset", 32'h0000_0000, lvec);
		srst <= 1'b0;
		repeat (INIT_CYC + 20) @(posedge clock);
		cmp_flag("ready held by option", 1'b0, link.ctrl_ready);
		option_done <= 1'b1;
		wait_link(32'h0000_0001, 32'h0000_0001, 40);
		give_verdict();
	end
endmodule
